// ---- common/dprs_pkg.sv ----
// constants, register map and types of the pll reference select bank
// assumes byte registers reached through the i2c slave, one clock
// Function
// RULE_01: ref1 priority uses 00 as first and 01 as second, resets to second, 10 and 11 unused.
// RULE_02: setting the ref0 exclude bit drops ref0 from automatic switchover, clear at reset.
// RULE_03: setting the ref1 exclude bit drops ref1 from automatic switchover, clear at reset.
// RULE_04: state control 00 runs automatically, 01 forces free run, 10 normal, 11 holdover.
// RULE_05: a host using the pll as a plain synthesizer should program the forced free-run code.
// RULE_06: ref0 has a 21-bit pre-divider resetting to zero, applied while ref0 is in use.
// RULE_07: ref1 has a 21-bit pre-divider resetting to zero, applied while ref1 is in use.
// RULE_08: hosts write zero to reserved bits, whose read value is not defined.
// RULE_09: each 24-bit feedback divider spans three bytes msb first, at 0x17 and 0x1a.
// RULE_10: modulator integer is 9 bits over 0x31 bit 0 and 0x32, fraction 21 bits over 0x33 to 0x35.
// RULE_11: reference select 000 is automatic, 001 by gpio, 100 forces ref0, 101 forces ref1.
// RULE_12: ref0 priority uses 00 as first and 01 as second, resets to first.
// RULE_13: a written state control value acts on the state machine one cycle after the write.
package dprs_pkg;
	localparam int NREG = 31;
	// byte addresses, entry 0 in the low byte
	localparam logic [NREG-1:0][7:0] REG_ADDR = {
		8'h3a, 8'h35, 8'h34, 8'h33, 8'h32, 8'h31, 8'h30, 8'h2f,
		8'h2e, 8'h2d, 8'h2c, 8'h2b, 8'h28, 8'h25, 8'h24, 8'h23,
		8'h1c, 8'h1b, 8'h1a, 8'h19, 8'h18, 8'h17, 8'h10, 8'h0f,
		8'h0e, 8'h0d, 8'h0c, 8'h0b, 8'h0a, 8'h09, 8'h08};
	// writable bits; reserved bits stay zero
	localparam logic [NREG-1:0][7:0] REG_MASK = {
		8'hf7, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h01, 8'hff, 8'hdb,
		8'h00, 8'h00, 8'h00, 8'h00, 8'hfe, 8'hfe, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'h1f, 8'hff, 8'hff, 8'h1f, 8'h33, 8'h0f, 8'hff};
	// reset values
	localparam logic [NREG-1:0][7:0] REG_RST = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h06, 8'h6d, 8'h77,
		8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h03};
	// entry indices
	localparam int IX_INPUT_CTRL = 0;
	localparam int IX_PRIORITY = 1;
	localparam int IX_EXCL_STATE = 2;
	localparam int IX_PRE0 = 3;
	localparam int IX_PRE1 = 6;
	localparam int IX_FB0 = 9;
	localparam int IX_FB1 = 12;
	localparam int IX_LOOP_BW = 15;
	localparam int IX_DAMPING = 16;
	localparam int IX_TIGHT_CTRL = 17;
	localparam int IX_TIGHT_THR = 18;
	localparam int IX_SLOPE_HOLD = 23;
	localparam int IX_LOCK = 24;
	localparam int IX_MOD_INT = 25;
	localparam int IX_MOD_FRAC = 27;
	localparam int IX_MOD_ORDER = 30;
	// field positions (lsb)
	localparam int POS_REF_SELECT = 5;
	localparam int POS_FB_SELECT = 2;
	localparam int POS_REVERT = 1;
	localparam int POS_PRI1 = 2;
	localparam int POS_PRI0 = 0;
	localparam int POS_EXCL1 = 5;
	localparam int POS_EXCL0 = 4;
	localparam int POS_STATE = 0;
	// codes
	localparam logic [2:0] SEL_AUTO = 3'h0;
	localparam logic [2:0] SEL_GPIO = 3'h1;
	localparam logic [2:0] SEL_REF0 = 3'h4;
	localparam logic [2:0] SEL_REF1 = 3'h5;
	localparam logic [1:0] FORCE_NONE = 2'h0;
	localparam logic [1:0] FORCE_FREE = 2'h1;
	localparam logic [1:0] FORCE_NORMAL = 2'h2;
	localparam logic [1:0] FORCE_HOLD = 2'h3;
	// arbitrary neutral default for the i2c device address
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

	typedef enum logic [1:0] {free_run_state, normal_state, holdover_state} dprs_pll_state_t;
endpackage

// ---- logic/dprs_i2c_slave.sv ----
// i2c target with byte pointer and auto increment
// assumes open-drain sda resolved outside; scl and sda are asynchronous pins
`timescale 1ns/1ps
module dprs_i2c_slave #(
	parameter logic [6:0] DEV_ADDR = dprs_pkg::DEV_ADDR_DEFAULT
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       reset,
	// pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// register side
	output logic            reg_wr,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	typedef enum logic [3:0] {idle, addr, addr_ack, ptr, ptr_ack, wdata, wack, rdata, rack} dprs_i2c_st_t;
	typedef struct packed {
		dprs_i2c_st_t st;
		logic [3:0]   cnt;
		logic [7:0]   sh;
		logic         rw;
		logic [7:0]   ptr;
		logic         drive;
		logic [2:0]   scl_s;
		logic [2:0]   sda_s;
		logic         scl_f;
		logic         sda_f;
		logic         wr;
		logic [7:0]   wd;
	} dprs_i2c_t;

	dprs_i2c_t s_ff, nxt_s;
	logic rise, fall, start, stop;

	// pin filter, edges and the byte engine
	always_comb begin
		nxt_s = s_ff;
		nxt_s.wr = 1'b0;
		nxt_s.scl_s = {s_ff.scl_s[1:0], scl_in};
		nxt_s.sda_s = {s_ff.sda_s[1:0], sda_in};
		// a change counts only once stages two and three agree
		if (s_ff.scl_s[1] == s_ff.scl_s[2]) begin
			nxt_s.scl_f = s_ff.scl_s[2];
		end
		if (s_ff.sda_s[1] == s_ff.sda_s[2]) begin
			nxt_s.sda_f = s_ff.sda_s[2];
		end
		rise = nxt_s.scl_f & ~s_ff.scl_f;
		fall = ~nxt_s.scl_f & s_ff.scl_f;
		start = s_ff.scl_f & nxt_s.scl_f & s_ff.sda_f & ~nxt_s.sda_f;
		stop = s_ff.scl_f & nxt_s.scl_f & ~s_ff.sda_f & nxt_s.sda_f;
		if (start) begin
			nxt_s.st = addr;
			nxt_s.cnt = 4'h0;
			nxt_s.drive = 1'b0;
		end else if (stop) begin
			nxt_s.st = idle;
			nxt_s.drive = 1'b0;
		end else if (rise) begin
			if (s_ff.st == addr || s_ff.st == ptr || s_ff.st == wdata) begin
				nxt_s.sh = {s_ff.sh[6:0], s_ff.sda_f};
				nxt_s.cnt = s_ff.cnt + 4'h1;
			end
			// master nack ends a read burst
			if (s_ff.st == rack && s_ff.sda_f) begin
				nxt_s.st = idle;
			end
		end else if (fall) begin
			unique case (s_ff.st)
				idle: begin
				end
				addr: if (s_ff.cnt == 4'h8) begin
					nxt_s.rw = s_ff.sh[0];
					nxt_s.drive = (s_ff.sh[7:1] == DEV_ADDR);
					nxt_s.st = (s_ff.sh[7:1] == DEV_ADDR) ? addr_ack : idle;
				end
				addr_ack: begin
					nxt_s.cnt = s_ff.rw ? 4'h1 : 4'h0;
					nxt_s.sh = reg_rdata;
					nxt_s.drive = s_ff.rw & ~reg_rdata[7];
					nxt_s.st = s_ff.rw ? rdata : ptr;
				end
				ptr: if (s_ff.cnt == 4'h8) begin
					nxt_s.ptr = s_ff.sh;
					nxt_s.drive = 1'b1;
					nxt_s.st = ptr_ack;
				end
				ptr_ack, wack: begin
					nxt_s.drive = 1'b0;
					nxt_s.cnt = 4'h0;
					nxt_s.st = wdata;
					if (s_ff.st == wack) begin
						nxt_s.ptr = s_ff.ptr + 8'h01;
					end
				end
				wdata: if (s_ff.cnt == 4'h8) begin
					nxt_s.wr = 1'b1;
					nxt_s.wd = s_ff.sh;
					nxt_s.drive = 1'b1;
					nxt_s.st = wack;
				end
				rdata: if (s_ff.cnt == 4'h8) begin
					// release sda for the master's acknowledge
					nxt_s.drive = 1'b0;
					nxt_s.ptr = s_ff.ptr + 8'h01;
					nxt_s.st = rack;
				end else begin
					nxt_s.drive = ~s_ff.sh[6];
					nxt_s.sh = {s_ff.sh[6:0], 1'b0};
					nxt_s.cnt = s_ff.cnt + 4'h1;
				end
				rack: begin
					nxt_s.sh = reg_rdata;
					nxt_s.drive = ~reg_rdata[7];
					nxt_s.cnt = 4'h1;
					nxt_s.st = rdata;
				end
			endcase
		end
	end

	// state register; pins idle high after reset
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_ff <= '{st: idle, cnt: 4'h0, sh: 8'h00, rw: 1'b0, ptr: 8'h00, drive: 1'b0,
				scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1, wr: 1'b0, wd: 8'h00};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = s_ff.drive;
	assign reg_wr = s_ff.wr;
	assign reg_addr = s_ff.ptr;
	assign reg_wdata = s_ff.wd;
endmodule

// ---- logic/dprs_regs.sv ----
// pll reference select and feedback register bank with selection logic
// assumes ref_ok inputs come from monitors on mclk; gpio select is a pin
`timescale 1ns/1ps
module dprs_regs #(
	parameter logic [6:0] DEV_ADDR = dprs_pkg::DEV_ADDR_DEFAULT
) (
	// clock and reset
	input  wire logic                     mclk,
	input  wire logic                     reset,
	// i2c pins
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe,
	// reference health and gpio choice
	input  wire logic                     ref0_ok,
	input  wire logic                     ref1_ok,
	input  wire logic                     gpio_ref_sel,
	// selection results
	output logic                          sel_ref,
	output logic                          sel_valid,
	output dprs_pkg::dprs_pll_state_t     pll_state,
	output logic [20:0]                   act_predivider,
	output logic [23:0]                   act_fb_divider,
	// decoded controls
	output logic [2:0]                    reference_select,
	output logic [2:0]                    feedback_select,
	output logic                          revertive,
	output logic                          phase_track,
	output logic [1:0]                    ref0_switch_priority,
	output logic [1:0]                    ref1_switch_priority,
	output logic                          ref0_switch_exclude,
	output logic                          ref1_switch_exclude,
	output logic [1:0]                    pll_state_force,
	output logic [20:0]                   ref0_predivider,
	output logic [20:0]                   ref1_predivider,
	output logic [23:0]                   fb_divider_ref0,
	output logic [23:0]                   fb_divider_ref1,
	output logic [8:0]                    modulator_integer,
	output logic [20:0]                   modulator_fraction,
	// raw feedback block bytes
	output logic [7:0]                    loop_bandwidth_select,
	output logic [7:0]                    damping_and_gain,
	output logic [7:0]                    tight_lock_control,
	output logic [7:0]                    tight_lock_threshold,
	output logic [7:0]                    slope_holdover_control,
	output logic [7:0]                    lock_setting,
	output logic [7:0]                    modulator_order_gain
);
	typedef struct packed {
		logic [dprs_pkg::NREG-1:0][7:0] regs;
		logic [2:0]                    gpio_s;
		logic                          gpio_f;
		logic                          sel_ref;
		logic                          sel_valid;
		dprs_pkg::dprs_pll_state_t     auto_st;
		dprs_pkg::dprs_pll_state_t     pll_st;
		logic [20:0]                   pre;
		logic [23:0]                   fb;
	} dprs_regs_t;

	localparam dprs_regs_t S_RST = '{
		regs: dprs_pkg::REG_RST,
		gpio_s: 3'h0,
		gpio_f: 1'b0,
		sel_ref: 1'b0,
		sel_valid: 1'b0,
		auto_st: dprs_pkg::free_run_state,
		pll_st: dprs_pkg::free_run_state,
		pre: 21'h000000,
		fb: 24'h070000};

	dprs_regs_t s_ff, nxt_s;
	logic       reg_wr;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       cand0, cand1;
	logic       pick;
	logic       have;
	logic [1:0] pri0, pri1;

	// serial access to the byte map
	dprs_i2c_slave #(
		.DEV_ADDR(DEV_ADDR)
	) u_i2c (
		.mclk      (mclk),
		.reset     (reset),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.sda_out   (sda_out),
		.sda_oe    (sda_oe),
		.reg_wr    (reg_wr),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_rdata (reg_rdata)
	);

	// read mux; reserved bits and unmapped bytes read zero, fixed bytes read ones
	always_comb begin
		reg_rdata = 8'h00;
		for (int i = 0; i < dprs_pkg::NREG; i++) begin
			if (reg_addr == dprs_pkg::REG_ADDR[i]) begin
				reg_rdata = s_ff.regs[i]; // [RULE_08] [RULE_09] [RULE_10]
			end
		end
	end

	// field views of the stored bytes
	always_comb begin
		reference_select = s_ff.regs[dprs_pkg::IX_INPUT_CTRL][dprs_pkg::POS_REF_SELECT +: 3];
		feedback_select = s_ff.regs[dprs_pkg::IX_INPUT_CTRL][dprs_pkg::POS_FB_SELECT +: 3];
		revertive = s_ff.regs[dprs_pkg::IX_INPUT_CTRL][dprs_pkg::POS_REVERT];
		phase_track = s_ff.regs[dprs_pkg::IX_INPUT_CTRL][0];
		ref0_switch_priority = s_ff.regs[dprs_pkg::IX_PRIORITY][dprs_pkg::POS_PRI0 +: 2]; // [RULE_12]
		ref1_switch_priority = s_ff.regs[dprs_pkg::IX_PRIORITY][dprs_pkg::POS_PRI1 +: 2]; // [RULE_01]
		ref0_switch_exclude = s_ff.regs[dprs_pkg::IX_EXCL_STATE][dprs_pkg::POS_EXCL0];
		ref1_switch_exclude = s_ff.regs[dprs_pkg::IX_EXCL_STATE][dprs_pkg::POS_EXCL1];
		pll_state_force = s_ff.regs[dprs_pkg::IX_EXCL_STATE][dprs_pkg::POS_STATE +: 2];
		ref0_predivider = {s_ff.regs[dprs_pkg::IX_PRE0][4:0], s_ff.regs[dprs_pkg::IX_PRE0+1],
			s_ff.regs[dprs_pkg::IX_PRE0+2]}; // [RULE_06]
		ref1_predivider = {s_ff.regs[dprs_pkg::IX_PRE1][4:0], s_ff.regs[dprs_pkg::IX_PRE1+1],
			s_ff.regs[dprs_pkg::IX_PRE1+2]}; // [RULE_07]
		// most significant byte sits at the lowest address
		fb_divider_ref0 = {s_ff.regs[dprs_pkg::IX_FB0], s_ff.regs[dprs_pkg::IX_FB0+1],
			s_ff.regs[dprs_pkg::IX_FB0+2]}; // [RULE_09]
		fb_divider_ref1 = {s_ff.regs[dprs_pkg::IX_FB1], s_ff.regs[dprs_pkg::IX_FB1+1],
			s_ff.regs[dprs_pkg::IX_FB1+2]}; // [RULE_09]
		modulator_integer = {s_ff.regs[dprs_pkg::IX_MOD_INT][0], s_ff.regs[dprs_pkg::IX_MOD_INT+1]}; // [RULE_10]
		modulator_fraction = {s_ff.regs[dprs_pkg::IX_MOD_FRAC][4:0], s_ff.regs[dprs_pkg::IX_MOD_FRAC+1],
			s_ff.regs[dprs_pkg::IX_MOD_FRAC+2]}; // [RULE_10]
		loop_bandwidth_select = s_ff.regs[dprs_pkg::IX_LOOP_BW];
		damping_and_gain = s_ff.regs[dprs_pkg::IX_DAMPING];
		tight_lock_control = s_ff.regs[dprs_pkg::IX_TIGHT_CTRL];
		tight_lock_threshold = s_ff.regs[dprs_pkg::IX_TIGHT_THR];
		slope_holdover_control = s_ff.regs[dprs_pkg::IX_SLOPE_HOLD];
		lock_setting = s_ff.regs[dprs_pkg::IX_LOCK];
		modulator_order_gain = s_ff.regs[dprs_pkg::IX_MOD_ORDER];
	end

	// automatic candidates and their priority order
	always_comb begin
		pri0 = ref0_switch_priority;
		pri1 = ref1_switch_priority;
		cand0 = ref0_ok & ~ref0_switch_exclude; // [RULE_02]
		cand1 = ref1_ok & ~ref1_switch_exclude; // [RULE_03]
		have = cand0 | cand1;
		// lower code is the higher priority; a tie favours ref0
		if (cand0 && cand1) begin
			pick = (pri1 < pri0); // [RULE_01] [RULE_12]
		end else begin
			pick = cand1 & ~cand0;
		end
		// non-revertive keeps a still usable current reference
		if (!revertive && s_ff.sel_valid && (s_ff.sel_ref ? cand1 : cand0)) begin
			pick = s_ff.sel_ref;
		end
	end

	// register writes, selection and pll state tracking
	always_comb begin
		nxt_s = s_ff;
		nxt_s.gpio_s = {s_ff.gpio_s[1:0], gpio_ref_sel};
		if (s_ff.gpio_s[1] == s_ff.gpio_s[2]) begin
			nxt_s.gpio_f = s_ff.gpio_s[2];
		end
		// masked write keeps reserved and fixed bits at their reset value
		for (int i = 0; i < dprs_pkg::NREG; i++) begin
			if (reg_wr && reg_addr == dprs_pkg::REG_ADDR[i]) begin
				nxt_s.regs[i] = (reg_wdata & dprs_pkg::REG_MASK[i])
					| (s_ff.regs[i] & ~dprs_pkg::REG_MASK[i]); // [RULE_08]
			end
		end
		// reserved select codes hold the previous choice
		unique case (reference_select)
			dprs_pkg::SEL_AUTO: begin
				nxt_s.sel_ref = have ? pick : s_ff.sel_ref;
				nxt_s.sel_valid = have; // [RULE_11]
			end
			dprs_pkg::SEL_GPIO: begin
				nxt_s.sel_ref = s_ff.gpio_f;
				nxt_s.sel_valid = s_ff.gpio_f ? ref1_ok : ref0_ok; // [RULE_11]
			end
			dprs_pkg::SEL_REF0: begin
				nxt_s.sel_ref = 1'b0;
				nxt_s.sel_valid = ref0_ok; // [RULE_11]
			end
			dprs_pkg::SEL_REF1: begin
				nxt_s.sel_ref = 1'b1;
				nxt_s.sel_valid = ref1_ok; // [RULE_11]
			end
			default: begin
			end
		endcase
		// dividers of whichever reference the pll is using
		nxt_s.pre = s_ff.sel_ref ? ref1_predivider : ref0_predivider; // [RULE_06] [RULE_07]
		nxt_s.fb = s_ff.sel_ref ? fb_divider_ref1 : fb_divider_ref0;
		// automatic state walk: free run until a reference, then normal or holdover
		unique case (s_ff.auto_st)
			dprs_pkg::free_run_state: if (s_ff.sel_valid) begin
				nxt_s.auto_st = dprs_pkg::normal_state;
			end
			dprs_pkg::normal_state: if (!s_ff.sel_valid) begin
				nxt_s.auto_st = dprs_pkg::holdover_state;
			end
			dprs_pkg::holdover_state: if (s_ff.sel_valid) begin
				nxt_s.auto_st = dprs_pkg::normal_state;
			end
			default: nxt_s.auto_st = dprs_pkg::free_run_state;
		endcase
		// force code read from the stored byte, so a write acts one cycle later
		unique case (pll_state_force)
			dprs_pkg::FORCE_NONE: nxt_s.pll_st = nxt_s.auto_st; // [RULE_04] [RULE_13]
			dprs_pkg::FORCE_FREE: nxt_s.pll_st = dprs_pkg::free_run_state; // [RULE_04] [RULE_13]
			dprs_pkg::FORCE_NORMAL: nxt_s.pll_st = dprs_pkg::normal_state; // [RULE_04] [RULE_13]
			dprs_pkg::FORCE_HOLD: nxt_s.pll_st = dprs_pkg::holdover_state; // [RULE_04] [RULE_13]
		endcase
	end

	// single state register
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_ff <= S_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign sel_ref = s_ff.sel_ref;
	assign sel_valid = s_ff.sel_valid;
	assign pll_state = s_ff.pll_st;
	assign act_predivider = s_ff.pre;
	assign act_fb_divider = s_ff.fb;
endmodule

// ---- tb/dprs_regs_sva.sv ----
// assertions on the ports of the reference select bank
// assumes a bind to dprs_regs; selection and dividers are registered
`timescale 1ns/1ps
module dprs_regs_sva (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  reset,
	// health and results
	input  wire logic                  ref0_ok,
	input  wire logic                  ref1_ok,
	input  wire logic                  sel_ref,
	input  wire logic                  sel_valid,
	input  dprs_pkg::dprs_pll_state_t  pll_state,
	input  wire logic [20:0]           act_predivider,
	input  wire logic [23:0]           act_fb_divider,
	// register fields
	input  wire logic [2:0]            reference_select,
	input  wire logic                  revertive,
	input  wire logic [1:0]            ref0_switch_priority,
	input  wire logic [1:0]            ref1_switch_priority,
	input  wire logic                  ref0_switch_exclude,
	input  wire logic                  ref1_switch_exclude,
	input  wire logic [1:0]            pll_state_force,
	input  wire logic [20:0]           ref0_predivider,
	input  wire logic [20:0]           ref1_predivider,
	input  wire logic [23:0]           fb_divider_ref0,
	input  wire logic [23:0]           fb_divider_ref1
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// both references compete; revertive so the priority alone decides
	wire logic auto_mode = reference_select == dprs_pkg::SEL_AUTO;
	wire logic both_in   = auto_mode && revertive && ref0_ok && ref1_ok && !ref0_switch_exclude && !ref1_switch_exclude;

	a_force_free_run: assert property (pll_state_force == dprs_pkg::FORCE_FREE |=> pll_state == dprs_pkg::free_run_state)
		else $error("forced free run not shown");
	a_force_normal_run: assert property (pll_state_force == dprs_pkg::FORCE_NORMAL |=> pll_state == dprs_pkg::normal_state)
		else $error("forced normal not shown");
	a_force_hold_next: assert property ($changed(pll_state_force) && pll_state_force == dprs_pkg::FORCE_HOLD |-> ##1 pll_state == dprs_pkg::holdover_state)
		else $error("forced holdover late");
	a_excl_ref0_skip: assert property (auto_mode && ref0_switch_exclude |=> !(sel_valid && !sel_ref))
		else $error("excluded ref0 selected");
	a_excl_ref1_skip: assert property (auto_mode && ref1_switch_exclude |=> !(sel_valid && sel_ref))
		else $error("excluded ref1 selected");
	a_pri_ref1_wins: assert property (both_in && ref1_switch_priority < ref0_switch_priority |=> sel_ref && sel_valid)
		else $error("ref1 priority ignored");
	a_pri_ref0_wins: assert property (both_in && ref0_switch_priority < ref1_switch_priority |=> !sel_ref && sel_valid)
		else $error("ref0 priority ignored");
	a_forced_ref_one: assert property (reference_select == dprs_pkg::SEL_REF1 && ref1_ok |=> sel_ref)
		else $error("forced ref1 not selected");
	a_prediv_ref0_use: assert property (!sel_ref |=> act_predivider == $past(ref0_predivider))
		else $error("ref0 pre-divider not applied");
	a_prediv_ref1_use: assert property (sel_ref |=> act_predivider == $past(ref1_predivider))
		else $error("ref1 pre-divider not applied");
	a_fb_div_ref1: assert property (sel_ref |=> act_fb_divider == $past(fb_divider_ref1))
		else $error("ref1 feedback divider not applied");
endmodule

// ---- tb/dprs_i2c_host.sv ----
// i2c master model that configures the bank byte by byte
// assumes sda has a pull-up and scl is driven only here; paced on mclk falls
`timescale 1ns/1ps
module dprs_i2c_host #(
	parameter logic [6:0] DEV_ADDR = dprs_pkg::DEV_ADDR_DEFAULT
) (
	// clock
	input  wire logic mclk,
	// bus lines
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	int unsigned nacks;
	// idle bus: both lines released, so scl stands high
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		nacks = 0;
	end
	// 9 cycles per phase keeps clear of the 4 cycle pin filter
	task automatic hold();
		repeat (9) @(negedge mclk);
	endtask
	// sda moves only mid low phase, never near an scl edge
	task automatic clk_bit(input logic b, output logic r);
		hold();
		sda_low = !b;
		hold();
		scl = 1'b1;
		hold();
		r = sda;
		scl = 1'b0;
	endtask
	task automatic start();
		hold();
		sda_low = 1'b0;
		hold();
		scl = 1'b1;
		hold();
		sda_low = 1'b1;
		hold();
		scl = 1'b0;
	endtask
	task automatic stop();
		hold();
		sda_low = 1'b1;
		hold();
		scl = 1'b1;
		hold();
		sda_low = 1'b0;
		hold();
	endtask
	// ack slot always released; chk counts a missing target ack
	task automatic xfer(input logic [7:0] d, input logic chk, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
		clk_bit(1'b1, a);
		if (chk && a) nacks++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, q);
		xfer(a, 1'b1, q);
		xfer(d, 1'b1, q);
		stop();
	endtask
	// random read: pointer write, repeated start, one byte ended by nack
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, q);
		xfer(a, 1'b1, q);
		start();
		xfer({DEV_ADDR, 1'b1}, 1'b1, q);
		xfer(8'hff, 1'b0, d);
		stop();
	endtask
endmodule

// ---- tb/tb_dprs_regs.sv ----
// self-checking bench for the reference select bank over i2c
// assumes a 100 MHz mclk and the host model as only bus master
`timescale 1ns/1ps
module tb_dprs_regs;
	logic                      mclk, reset, scl, m_low, ref0_ok, ref1_ok, gpio_ref_sel;
	logic                      sda_oe, sel_ref, sel_valid, revertive, ref0_switch_exclude, ref1_switch_exclude;
	dprs_pkg::dprs_pll_state_t pll_state;
	logic [2:0]                reference_select;
	logic [1:0]                ref0_switch_priority, ref1_switch_priority, pll_state_force;
	logic [20:0]               act_predivider, ref0_predivider, ref1_predivider, modulator_fraction;
	logic [23:0]               act_fb_divider, fb_divider_ref0, fb_divider_ref1;
	logic [8:0]                modulator_integer;
	logic [7:0]                rd_data;
	int                        mismatches, checks, cycles;
	wire logic                 sda = !(sda_oe || m_low);  // open drain with pull-up
	// rows: write flag, address, data, expected read
	logic [27:0] rows [0:29] = '{28'h0_08_00_03, 28'h0_09_00_04, 28'h0_0a_00_00, 28'h0_0b_00_00,
		28'h0_17_00_07, 28'h0_2b_00_ff, 28'h0_23_00_77, 28'h1_40_5a_00, 28'h1_09_01_01, 28'h1_0a_31_31,
		28'h1_0b_1f_1f, 28'h1_0c_a5_a5, 28'h1_0d_3c_3c, 28'h1_0e_12_12, 28'h1_0f_34_34, 28'h1_10_56_56,
		28'h1_17_12_12, 28'h1_18_34_34, 28'h1_19_56_56, 28'h1_1a_ab_ab, 28'h1_1b_cd_cd, 28'h1_1c_ef_ef,
		28'h1_31_01_01, 28'h1_32_5a_5a, 28'h1_33_15_15, 28'h1_34_67_67, 28'h1_35_89_89, 28'h0_2e_00_ff,
		28'h0_0a_00_31, 28'h0_09_00_01};
	// selection rows: address, data, expected selected reference
	logic [19:0] sel_rows [0:6] = '{20'h0a_00_1, 20'h09_04_0, 20'h0a_10_1, 20'h0a_20_0,
		20'h08_a2_1, 20'h08_82_0, 20'h08_22_1};
	dprs_pkg::dprs_pll_state_t st_exp [0:3] = '{dprs_pkg::normal_state, dprs_pkg::free_run_state,
		dprs_pkg::normal_state, dprs_pkg::holdover_state};

	dprs_regs u_dprs_regs (.mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.ref0_ok(ref0_ok), .ref1_ok(ref1_ok), .gpio_ref_sel(gpio_ref_sel), .sel_ref(sel_ref), .sel_valid(sel_valid),
		.pll_state(pll_state), .act_predivider(act_predivider), .act_fb_divider(act_fb_divider),
		.reference_select(reference_select), .feedback_select(), .revertive(revertive), .phase_track(),
		.ref0_switch_priority(ref0_switch_priority), .ref1_switch_priority(ref1_switch_priority),
		.ref0_switch_exclude(ref0_switch_exclude), .ref1_switch_exclude(ref1_switch_exclude),
		.pll_state_force(pll_state_force), .ref0_predivider(ref0_predivider), .ref1_predivider(ref1_predivider),
		.fb_divider_ref0(fb_divider_ref0), .fb_divider_ref1(fb_divider_ref1), .modulator_integer(modulator_integer),
		.modulator_fraction(modulator_fraction), .loop_bandwidth_select(), .damping_and_gain(),
		.tight_lock_control(), .tight_lock_threshold(), .slope_holdover_control(), .lock_setting(),
		.modulator_order_gain());
	dprs_i2c_host u_dprs_i2c_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(m_low));

	// clock and hang guard; a full run needs about 58000 cycles
	always #5 mclk = !mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 90000) begin
			mismatches++;
			$display("[FAIL] %0t timeout", $time);
			end_of_test();
		end
	end
	task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// main sequence: table, selection, state forcing, loss, reset
	initial begin
		mclk = 1'b0;
		reset = 1'b1;
		ref0_ok = 1'b1;
		ref1_ok = 1'b1;
		gpio_ref_sel = 1'b1;
		repeat (8) @(negedge mclk);
		reset = 1'b0;
		repeat (6) @(negedge mclk);
		foreach (rows[i]) begin
			if (rows[i][24]) u_dprs_i2c_host.wr(rows[i][23:16], rows[i][15:8]);
			u_dprs_i2c_host.rd(rows[i][23:16], rd_data);
			check(24'(rd_data), 24'(rows[i][7:0]), "readback");
		end
		check(24'(ref0_predivider), 24'h1fa53c, "pre0");
		check(24'(ref1_predivider), 24'h123456, "pre1");
		check(fb_divider_ref0, 24'h123456, "fb0");
		check(fb_divider_ref1, 24'habcdef, "fb1");
		check(24'(modulator_integer), 24'h00015a, "int");
		check(24'(modulator_fraction), 24'h156789, "frac");
		check(24'({ref1_switch_priority, ref0_switch_priority}), 24'h000001, "pri");
		check(24'({ref1_switch_exclude, ref0_switch_exclude}), 24'h000003, "excl");
		check(24'(pll_state), 24'(dprs_pkg::free_run_state), "forced free");
		// selection follows priority, exclusion and forced choice
		foreach (sel_rows[i]) begin
			u_dprs_i2c_host.wr(sel_rows[i][19:12], sel_rows[i][11:4]);
			check(24'({sel_valid, sel_ref}), 24'({1'b1, sel_rows[i][0]}), "selection");
			check(24'(act_predivider), sel_rows[i][0] ? 24'h123456 : 24'h1fa53c, "active pre");
			check(act_fb_divider, sel_rows[i][0] ? 24'habcdef : 24'h123456, "active fb");
		end
		// every state control code, gpio mode keeps ref1 valid
		for (int c = 0; c < 4; c++) begin
			u_dprs_i2c_host.wr(8'h0a, 8'(c));
			check(24'(pll_state), 24'(st_exp[c]), "state code");
		end
		// losing the gpio-chosen reference means holdover
		u_dprs_i2c_host.wr(8'h0a, 8'h00);
		ref1_ok = 1'b0;
		repeat (6) @(negedge mclk);
		check(24'({sel_valid, 2'(pll_state)}), 24'({1'b0, 2'(dprs_pkg::holdover_state)}), "loss");
		ref1_ok = 1'b1;
		// reset in mid run restores the documented values
		reset = 1'b1;
		repeat (3) @(negedge mclk);
		reset = 1'b0;
		repeat (2) @(negedge mclk);
		check(24'({ref1_switch_priority, pll_state_force}), 24'h000004, "reset ctl");
		check(24'(ref0_predivider), 24'h000000, "reset pre");
		check(fb_divider_ref1, 24'h070000, "reset fb");
		check(24'(u_dprs_i2c_host.nacks), 24'h000000, "nacks");
		end_of_test();
	end
endmodule

bind dprs_regs dprs_regs_sva u_dprs_regs_sva (.mclk(mclk), .reset(reset), .ref0_ok(ref0_ok), .ref1_ok(ref1_ok),
	.sel_ref(sel_ref), .sel_valid(sel_valid), .pll_state(pll_state), .act_predivider(act_predivider),
	.act_fb_divider(act_fb_divider), .reference_select(reference_select), .revertive(revertive),
	.ref0_switch_priority(ref0_switch_priority), .ref1_switch_priority(ref1_switch_priority),
	.ref0_switch_exclude(ref0_switch_exclude), .ref1_switch_exclude(ref1_switch_exclude),
	.pll_state_force(pll_state_force), .ref0_predivider(ref0_predivider), .ref1_predivider(ref1_predivider),
	.fb_divider_ref0(fb_divider_ref0), .fb_divider_ref1(fb_divider_ref1));
